// file: core/lpm_pkg.sv
// Package: register map, fields, timing and states of the low-power sequencer
package lpm_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CSTS = 8'h04;
	localparam logic [7:0] OFS_CORE = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	// Control register fields
	localparam int CTRL_LPDS = 0;
	localparam int CTRL_PDDS = 1;
	localparam int CTRL_WUCLR = 2;
	localparam int CTRL_SBCLR = 3;
	localparam int CTRL_PVDEN = 4;
	localparam int CTRL_BPWEN = 8;
	localparam int CTRL_FPDSM = 9;
	localparam int CTRL_VOS = 14;
	localparam logic [31:0] CTRL_RESET = 32'h0000_4000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_43F3;
	// Status register fields
	localparam int CSTS_WUE = 0;
	localparam int CSTS_SB = 1;
	// Core-side control fields
	localparam int CORE_SOE = 0;
	localparam int CORE_DEEP = 1;
	// Interrupt status fields
	localparam int IRQ_W = 4;
	localparam int IRQ_SLEEP = 0;
	localparam int IRQ_STOP = 1;
	localparam int IRQ_STBY = 2;
	localparam int IRQ_WAKE = 3;
	// Timing, 250 MHz clock
	localparam int CLK_PERIOD_PS = 4000;
	localparam int HSI_START_NS = 2000;
	localparam int REG_RECOVER_NS = 8000;
	localparam int CHIP_RESET_NS = 4000;
	localparam int HSI_CYC = (HSI_START_NS * 1000) / CLK_PERIOD_PS;
	localparam int REG_CYC = (REG_RECOVER_NS * 1000) / CLK_PERIOD_PS;
	localparam int RST_CYC = (CHIP_RESET_NS * 1000) / CLK_PERIOD_PS;
	localparam int WUFLG_CLR_DLY = 2;
	localparam int WAKE_SRC_N = 6;
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_SLEEP = 3'b001,
		ST_STOP = 3'b010,
		ST_STBY = 3'b011,
		ST_WAKE = 3'b100,
		ST_ISR = 3'b101
	} lpm_state_e;
endpackage

// file: core/lpm_edge.sv
`timescale 1ns/1ps
// Per-source rising edge detector for wake inputs
module lpm_edge #(
	parameter int N = 6
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Levels in, pulses out
	input wire logic [N-1:0] lvl_i,
	output logic [N-1:0] rise_o
);
	logic [N-1:0] prev_ff;

	initial begin
		if (N < 1) $error("N must be positive");
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_src
			always_ff @(posedge clk_i) begin
				if (!rst_b_i) begin
					prev_ff[g] <= 1'b0;
				end else begin
					prev_ff[g] <= lvl_i[g];
				end
			end
			assign rise_o[g] = lvl_i[g] & ~prev_ff[g];
		end
	endgenerate
endmodule

// file: core/lpm_timer.sv
`timescale 1ns/1ps
// Down counter timing wake-up latency
module lpm_timer #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Load and status
	input wire logic load_i,
	input wire logic [W-1:0] count_i,
	output logic done_o
);
	logic [W-1:0] cnt_ff;

	initial begin
		if (W < 2) $error("W too small");
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cnt_ff <= '0;
		end else if (load_i) begin
			cnt_ff <= count_i;
		end else if (cnt_ff != '0) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

	// Done in the last counted cycle, so a load of N lasts N cycles
	assign done_o = (cnt_ff <= W'(1)) & ~load_i;
endmodule

// file: core/lpm_ctrl.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// Low-power mode sequencer: sleep, stop and standby control
// Function
// - sleep on wait when deep sleep is off
// - irq wakes irq wait, event wakes event wait
// - sleep halts only core clock
// - irq wake runs handler, event resumes
// - deep and not powerdown enters stop
// - stop regulator low power follows setting
// - stop halts core and peripherals, retains
// - stop latency oscillator, plus regulator recovery if low power
// - deep, powerdown, flag clear enters standby
// - standby left on pin, rtc, resets
// - standby stops all, loses contents
// - standby wake takes chip reset time
// - rtc events wake stop and standby
// - powerdown select chooses standby over stop
// - standby flag set, cleared by write
// - wake event flag set by sources
module lpm_ctrl
	import lpm_pkg::*;
#(
	parameter int TW = 16
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// Register port
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O,
	// Core side
	input wire logic WAIT_FOR_INTERRUPT_I,
	input wire logic WAIT_FOR_EVENT_I,
	input wire logic IRQ_I,
	input wire logic EVENT_I,
	input wire logic ISR_RETURN_I,
	input wire logic POR_I,
	// Wake sources: pin, alarm, wakeup, tamper, timestamp, reset pin, watchdog
	input wire logic WAKE_PIN_I,
	input wire logic RTC_ALARM_I,
	input wire logic RTC_WAKEUP_I,
	input wire logic RTC_TAMPER_I,
	input wire logic RTC_TSTAMP_I,
	input wire logic EXT_RESET_PIN_I,
	input wire logic WATCHDOG_RST_I,
	// Power controls
	output logic CORE_CLK_EN_O,
	output logic PERIPH_CLK_EN_O,
	output logic REG_LOWPOWER_O,
	output logic REG_OFF_O,
	output logic RETAIN_LOST_O,
	output logic CHIP_RESET_O,
	output logic SERVICE_IRQ_O,
	output logic [2:0] MODE_O,
	// Interrupt
	output logic INT_O
);
	lpm_state_e state_ff, nxt_state;
	logic [31:0] ctrl_ff;
	logic wue_ff, sb_ff;
	logic soe_ff, deep_ff;
	logic via_event_ff;
	logic [TW-1:0] wake_len_ff;
	logic lp_used_ff;
	logic [1:0] wuclr_ff;
	logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff, irq_set;
	logic [WAKE_SRC_N-1:0] src_lvl, src_rise;
	logic any_rtc, wake_evt, stby_wake, wait_any;
	logic tmr_load, tmr_done;
	logic [TW-1:0] tmr_count;
	logic wr_ctrl, wr_core, wr_stat, wr_mask;

	initial begin
		if (REG_CYC + HSI_CYC >= (1 << TW) || RST_CYC >= (1 << TW))
			$error("TW too narrow for wake-up latency");
	end

	assign src_lvl = {WATCHDOG_RST_I, RTC_TSTAMP_I, RTC_TAMPER_I,
		RTC_WAKEUP_I, RTC_ALARM_I, WAKE_PIN_I};

	lpm_edge #(.N(WAKE_SRC_N)) u_edge (
		.clk_i(CLOCK_I),
		.rst_b_i(RST_B_I),
		.lvl_i(src_lvl),
		.rise_o(src_rise)
	);

	lpm_timer #(.W(TW)) u_timer (
		.clk_i(CLOCK_I),
		.rst_b_i(RST_B_I),
		.load_i(tmr_load),
		.count_i(tmr_count),
		.done_o(tmr_done)
	);

	assign any_rtc = |src_rise[4:1];
	assign wake_evt = src_rise[0] | any_rtc;
	assign stby_wake = wake_evt | EXT_RESET_PIN_I | WATCHDOG_RST_I;
	assign wait_any = WAIT_FOR_INTERRUPT_I | WAIT_FOR_EVENT_I;
	assign wr_ctrl = WR_I && ADDR_I == OFS_CTRL;
	assign wr_core = WR_I && ADDR_I == OFS_CORE;
	assign wr_stat = WR_I && ADDR_I == OFS_IRQ_STAT;
	assign wr_mask = WR_I && ADDR_I == OFS_IRQ_MASK;

	// Control register; cleared to reset value when standby wakes
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I || (state_ff == ST_STBY && stby_wake)) begin
			ctrl_ff <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_ff <= WDATA_I & CTRL_WMASK;
		end
	end

	// Core-side deep sleep and sleep-on-exit settings
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I || (state_ff == ST_STBY && stby_wake)) begin
			soe_ff <= 1'b0;
			deep_ff <= 1'b0;
		end else if (wr_core) begin
			soe_ff <= WDATA_I[CORE_SOE];
			deep_ff <= WDATA_I[CORE_DEEP];
		end
	end

	// Wake flag clear takes effect two clocks after the write
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			wuclr_ff <= 2'h0;
		end else begin
			wuclr_ff <= {wuclr_ff[0], wr_ctrl & WDATA_I[CTRL_WUCLR]};
		end
	end

	// Wake event flag: a set wins over a clear
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			wue_ff <= 1'b0;
		end else if (wake_evt) begin
			wue_ff <= 1'b1;
		end else if (wuclr_ff[1]) begin
			wue_ff <= 1'b0;
		end
	end

	// Standby flag: survives standby wake, cleared by POR or write
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			sb_ff <= 1'b0;
		end else if (nxt_state == ST_STBY && state_ff != ST_STBY) begin
			sb_ff <= 1'b1;
		end else if (POR_I || (wr_ctrl && WDATA_I[CTRL_SBCLR])) begin
			sb_ff <= 1'b0;
		end
	end

	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		tmr_load = 1'b0;
		tmr_count = '0;
		case (state_ff)
			ST_RUN: begin
				if (wait_any && !deep_ff) begin
					nxt_state = ST_SLEEP;
				end else if (wait_any && !ctrl_ff[CTRL_PDDS]) begin
					nxt_state = ST_STOP;
				end else if (wait_any && !wue_ff) begin
					nxt_state = ST_STBY;
				end
			end
			ST_ISR: begin
				if (ISR_RETURN_I) begin
					nxt_state = soe_ff ? ST_SLEEP : ST_RUN;
				end
			end
			ST_SLEEP: begin
				if (via_event_ff ? EVENT_I : IRQ_I) begin
					nxt_state = via_event_ff ? ST_RUN : ST_ISR;
				end
			end
			ST_STOP: begin
				if ((via_event_ff ? EVENT_I : IRQ_I) || any_rtc) begin
					nxt_state = ST_WAKE;
					tmr_load = 1'b1;
					tmr_count = TW'(lp_used_ff ? HSI_CYC + REG_CYC : HSI_CYC);
				end
			end
			ST_STBY: begin
				if (stby_wake) begin
					nxt_state = ST_WAKE;
					tmr_load = 1'b1;
					tmr_count = TW'(RST_CYC);
				end
			end
			ST_WAKE: begin
				if (tmr_done) begin
					nxt_state = via_event_ff || REG_OFF_O ? ST_RUN : ST_ISR;
				end
			end
			default: nxt_state = ST_RUN;
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			state_ff <= ST_RUN;
			via_event_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == ST_RUN && wait_any) begin
				via_event_ff <= WAIT_FOR_EVENT_I & ~WAIT_FOR_INTERRUPT_I;
			end
		end
	end

	// Regulator mode latched at stop entry; standby uses reset-kind wake
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			lp_used_ff <= 1'b0;
		end else if (state_ff == ST_RUN && nxt_state == ST_STOP) begin
			lp_used_ff <= ctrl_ff[CTRL_LPDS];
		end else if (state_ff == ST_RUN && nxt_state == ST_STBY) begin
			lp_used_ff <= 1'b0;
		end
	end

	// Power control outputs
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			CORE_CLK_EN_O <= 1'b1;
			PERIPH_CLK_EN_O <= 1'b1;
			REG_LOWPOWER_O <= 1'b0;
			REG_OFF_O <= 1'b0;
			RETAIN_LOST_O <= 1'b0;
			CHIP_RESET_O <= 1'b0;
		end else begin
			CORE_CLK_EN_O <= nxt_state == ST_RUN || nxt_state == ST_ISR;
			PERIPH_CLK_EN_O <= nxt_state != ST_STOP &&
				nxt_state != ST_STBY;
			REG_LOWPOWER_O <= nxt_state == ST_STOP &&
				(state_ff == ST_STOP ? lp_used_ff : ctrl_ff[CTRL_LPDS]);
			if (nxt_state == ST_STBY) begin
				REG_OFF_O <= 1'b1;
				RETAIN_LOST_O <= 1'b1;
			end else if (nxt_state == ST_RUN || nxt_state == ST_ISR) begin
				REG_OFF_O <= 1'b0;
				RETAIN_LOST_O <= 1'b0;
			end
			CHIP_RESET_O <= nxt_state == ST_WAKE && REG_OFF_O;
		end
	end

	assign SERVICE_IRQ_O = state_ff == ST_ISR;
	assign MODE_O = state_ff;

	// Interrupt status: sleep, stop, standby entry and wake
	assign irq_set = {wake_evt,
		nxt_state == ST_STBY && state_ff != ST_STBY,
		nxt_state == ST_STOP && state_ff != ST_STOP,
		nxt_state == ST_SLEEP && state_ff != ST_SLEEP};

	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			irq_stat_ff <= '0;
		end else begin
			irq_stat_ff <= irq_set |
				(irq_stat_ff & ~(wr_stat ? WDATA_I[IRQ_W-1:0] : '0));
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			irq_mask_ff <= '0;
		end else if (wr_mask) begin
			irq_mask_ff <= WDATA_I[IRQ_W-1:0];
		end
	end
	assign INT_O = |(irq_stat_ff & irq_mask_ff);

	// Read data one cycle after the strobe
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			RDATA_O <= 32'h0000_0000;
		end else if (RD_I) begin
			case (ADDR_I)
				OFS_CTRL: RDATA_O <= ctrl_ff;
				OFS_CSTS: RDATA_O <= {30'h0, sb_ff, wue_ff};
				OFS_CORE: RDATA_O <= {30'h0, deep_ff, soe_ff};
				OFS_IRQ_STAT: RDATA_O <= {28'h0, irq_stat_ff};
				OFS_IRQ_MASK: RDATA_O <= {28'h0, irq_mask_ff};
				default: RDATA_O <= 32'h0000_0000;
			endcase
		end else begin
			RDATA_O <= 32'h0000_0000;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I || state_ff != ST_WAKE) begin
			wake_len_ff <= '0;
		end else begin
			wake_len_ff <= wake_len_ff + 1'b1;
		end
	end

	property p_sleep_entry;
		@(posedge CLOCK_I) disable iff (!RST_B_I)
		state_ff == ST_RUN && wait_any && !deep_ff |=> state_ff == ST_SLEEP;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("wait without deep sleep did not sleep");
	property p_stop_entry;
		@(posedge CLOCK_I) disable iff (!RST_B_I)
		state_ff == ST_RUN && wait_any && deep_ff && !ctrl_ff[CTRL_PDDS]
		|=> state_ff == ST_STOP && !PERIPH_CLK_EN_O && !CORE_CLK_EN_O;
	endproperty
	a_stop_entry: assert property (p_stop_entry)
		else $error("stop not entered");
	property p_stby_block;
		@(posedge CLOCK_I) disable iff (!RST_B_I)
		state_ff == ST_RUN && wait_any && deep_ff && ctrl_ff[CTRL_PDDS] && wue_ff
		|=> state_ff == ST_RUN;
	endproperty
	a_stby_block: assert property (p_stby_block)
		else $error("standby entered with wake flag set");
	property p_stby_flag;
		@(posedge CLOCK_I) disable iff (!RST_B_I)
		state_ff == ST_RUN && nxt_state == ST_STBY |=> sb_ff && REG_OFF_O;
	endproperty
	a_stby_flag: assert property (p_stby_flag)
		else $error("standby flag not set");
	property p_wake_flag;
		@(posedge CLOCK_I) disable iff (!RST_B_I)
		wake_evt |=> wue_ff;
	endproperty
	a_wake_flag: assert property (p_wake_flag)
		else $error("wake flag missed");
	property p_sleep_clk;
		@(posedge CLOCK_I) disable iff (!RST_B_I)
		state_ff == ST_SLEEP |-> PERIPH_CLK_EN_O && !CORE_CLK_EN_O;
	endproperty
	a_sleep_clk: assert property (p_sleep_clk)
		else $error("sleep clocks wrong");
	property p_event_wake;
		@(posedge CLOCK_I) disable iff (!RST_B_I)
		state_ff == ST_SLEEP && via_event_ff && EVENT_I |=> state_ff == ST_RUN;
	endproperty
	a_event_wake: assert property (p_event_wake)
		else $error("event wake did not resume");
	property p_stop_lat;
		@(posedge CLOCK_I) disable iff (!RST_B_I)
		state_ff == ST_WAKE && nxt_state != ST_WAKE && !REG_OFF_O
		|-> wake_len_ff ==
			TW'(lp_used_ff ? HSI_CYC + REG_CYC - 1 : HSI_CYC - 1);
	endproperty
	a_stop_lat: assert property (p_stop_lat)
		else $error("stop wake latency wrong");
	property p_stby_wake;
		@(posedge CLOCK_I) disable iff (!RST_B_I)
		state_ff == ST_STBY && stby_wake |=> CHIP_RESET_O && ctrl_ff == CTRL_RESET;
	endproperty
	a_stby_wake: assert property (p_stby_wake)
		else $error("standby wake missed");
endmodule

// file: dv/lpm_core_model.sv
// Processor core model: wait instructions and handler return
`timescale 1ns/1ps
module lpm_core_model #(
	parameter int HANDLER_CYC = 6
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Commands from the bench
	input wire logic wait_irq_req_i,
	input wire logic wait_evt_req_i,
	// Core pins
	input wire logic service_irq_i,
	output logic wait_irq_o,
	output logic wait_evt_o,
	output logic isr_return_o
);
	int cnt_ff;
	always_ff @(posedge clk_i) begin
		wait_irq_o <= rst_b_i & wait_irq_req_i;
		wait_evt_o <= rst_b_i & wait_evt_req_i;
	end
	// Handler runs a few cycles and returns once per entry
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || !service_irq_i) begin
			cnt_ff <= 0;
			isr_return_o <= 1'b0;
		end else begin
			if (cnt_ff < HANDLER_CYC)
				cnt_ff <= cnt_ff + 1;
			isr_return_o <= (cnt_ff == HANDLER_CYC - 1);
		end
	end
endmodule

// file: dv/lpm_tb.sv
// Self-checking bench for the low-power sequencer
`timescale 1ns/1ps
module tb_top;
	import lpm_pkg::*;
	logic clk, rst_b, wr, rd, irq, evt, por, wait_irq_req, wait_evt_req;
	logic wait_irq, wait_evt, isr_ret, core_en, per_en, reglp, regoff, lost;
	logic chiprst, svc, intr;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [6:0] wsrc;
	logic [2:0] mode;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;

	lpm_ctrl lpm_ctrl_inst (.CLOCK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.WAIT_FOR_INTERRUPT_I(wait_irq), .WAIT_FOR_EVENT_I(wait_evt),
		.IRQ_I(irq), .EVENT_I(evt),
		.ISR_RETURN_I(isr_ret), .POR_I(por), .WAKE_PIN_I(wsrc[0]),
		.RTC_ALARM_I(wsrc[1]), .RTC_WAKEUP_I(wsrc[2]),
		.RTC_TAMPER_I(wsrc[3]), .RTC_TSTAMP_I(wsrc[4]),
		.EXT_RESET_PIN_I(wsrc[5]), .WATCHDOG_RST_I(wsrc[6]),
		.CORE_CLK_EN_O(core_en), .PERIPH_CLK_EN_O(per_en),
		.REG_LOWPOWER_O(reglp), .REG_OFF_O(regoff), .RETAIN_LOST_O(lost),
		.CHIP_RESET_O(chiprst), .SERVICE_IRQ_O(svc), .MODE_O(mode),
		.INT_O(intr));
	lpm_core_model lpm_core_model_inst (.clk_i(clk), .rst_b_i(rst_b),
		.wait_irq_req_i(wait_irq_req), .wait_evt_req_i(wait_evt_req),
		.service_irq_i(svc), .wait_irq_o(wait_irq), .wait_evt_o(wait_evt),
		.isr_return_o(isr_ret));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic end_of_test();
		if (failures == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata & m, exp);
	endtask

	task automatic wait_mode(input logic [2:0] m);
		int n = 0;
		#1;
		while (mode !== m && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(mode, m);
	endtask

	// Length of stay in a mode, counted from its first cycle
	task automatic span(input logic [2:0] m, input int exp);
		int n = 0;
		while (mode === m && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(n, exp);
	endtask

	task automatic go(input logic use_evt);
		@(posedge clk);
		wait_irq_req <= !use_evt;
		wait_evt_req <= use_evt;
		@(posedge clk);
		wait_irq_req <= 1'b0;
		wait_evt_req <= 1'b0;
	endtask

	task automatic pulse_src(input int i);
		@(posedge clk);
		wsrc[i] <= 1'b1;
		@(posedge clk);
		wsrc[i] <= 1'b0;
	endtask

	task automatic irq_cycle(input logic [2:0] fin);
		@(posedge clk);
		irq <= 1'b1;
		wait_mode(ST_ISR);
		chk(svc, 1'b1);
		@(posedge clk);
		irq <= 1'b0;
		wait_mode(fin);
	endtask

	task automatic t_regs();
		rdc(OFS_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
		wrt(OFS_CTRL, 32'hFFFF_FFF3);
		rdc(OFS_CTRL, 32'hFFFF_FFFF, CTRL_WMASK);
		rdc(8'h3C, 32'hFFFF_FFFF, 32'h0);
		wrt(OFS_CTRL, CTRL_RESET);
	endtask

	task automatic t_sleep();
		logic saw = 1'b0;
		wrt(OFS_CORE, 32'h0);
		go(1'b0);
		wait_mode(ST_SLEEP);
		chk({core_en, per_en, lost, reglp}, 4'b0100);
		@(posedge clk);
		evt <= 1'b1;
		@(posedge clk);
		evt <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk(mode, ST_SLEEP);
		irq_cycle(ST_RUN);
		wrt(OFS_CORE, 32'h1);
		go(1'b0);
		wait_mode(ST_SLEEP);
		irq_cycle(ST_SLEEP);
		wrt(OFS_CORE, 32'h0);
		irq_cycle(ST_RUN);
		go(1'b1);
		wait_mode(ST_SLEEP);
		@(posedge clk);
		irq <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk(mode, ST_SLEEP);
		@(posedge clk);
		irq <= 1'b0;
		evt <= 1'b1;
		@(posedge clk);
		evt <= 1'b0;
		repeat (10) begin
			@(posedge clk);
			#1;
			saw |= (mode === ST_ISR);
		end
		chk(saw, 1'b0);
		chk(mode, ST_RUN);
	endtask

	task automatic t_stop();
		for (int lp = 0; lp < 2; lp++) begin
			wrt(OFS_CORE, 32'h2);
			wrt(OFS_CTRL, CTRL_RESET | lp);
			go(lp == 0);
			wait_mode(ST_STOP);
			chk({core_en, per_en, lost, reglp}, lp);
			pulse_src(1 + 2 * lp);
			wait_mode(ST_WAKE);
			span(ST_WAKE, HSI_CYC + lp * REG_CYC);
			chk(mode, lp ? ST_ISR : ST_RUN);
			wait_mode(ST_RUN);
		end
	endtask

	task automatic t_standby();
		for (int i = 0; i < 7; i++) begin
			wrt(OFS_CTRL, CTRL_RESET | 32'h6);
			wrt(OFS_CORE, 32'h2);
			repeat (3) @(posedge clk);
			go(i % 2);
			wait_mode(ST_STBY);
			chk({lost, regoff, core_en, per_en}, 4'b1100);
			pulse_src(i);
			wait_mode(ST_WAKE);
			chk(chiprst, 1'b1);
			span(ST_WAKE, RST_CYC);
			chk(mode, ST_RUN);
			rdc(OFS_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
			rdc(OFS_CSTS, 32'h3, (i < 5) ? 3 : 2);
			if (i < 5) begin
				wrt(OFS_CORE, 32'h2);
				wrt(OFS_CTRL, CTRL_RESET | 32'h2);
				go(1'b0);
				repeat (5) @(posedge clk);
				#1;
				chk(mode, ST_RUN);
			end
			if (i == 6) begin
				@(posedge clk);
				por <= 1'b1;
				@(posedge clk);
				por <= 1'b0;
			end else
				wrt(OFS_CTRL, CTRL_RESET | 32'h8);
			rdc(OFS_CSTS, 32'h2, 32'h0);
		end
	endtask

	task automatic t_irq();
		rdc(OFS_IRQ_STAT, 32'hF, 32'hF);
		wrt(OFS_IRQ_MASK, 32'h0);
		#1;
		chk(intr, 1'b0);
		wrt(OFS_IRQ_MASK, 32'hF);
		#1;
		chk(intr, 1'b1);
		wrt(OFS_IRQ_STAT, 32'hF);
		#1;
		chk(intr, 1'b0);
		rdc(OFS_IRQ_STAT, 32'hF, 32'h0);
	endtask

	initial begin
		rst_b = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		irq = 1'b0;
		evt = 1'b0;
		por = 1'b0;
		wait_irq_req = 1'b0;
		wait_evt_req = 1'b0;
		wsrc = 7'h00;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_sleep();
		t_stop();
		t_standby();
		t_irq();
		end_of_test();
	end
endmodule
